// ===== afmc_defs.vh
/*
  constants for the adc filter and mode control block: register offsets,
  field codes, reset values and timing counts.
  assumes a 50 mhz core clock; included by bare name.
*/
`ifndef AFMC_DEFS_VH
`define AFMC_DEFS_VH

// register byte offsets on the wishbone bus
`define AFMC_OFS_CTRL      8'h00
`define AFMC_OFS_RATE      8'h04
`define AFMC_OFS_MANUAL    8'h08
`define AFMC_OFS_LP        8'h0C
`define AFMC_OFS_STATUS    8'h10
`define AFMC_OFS_RESULT    8'h14

// operating modes
`define AFMC_PM_HIPERF     2'b00
`define AFMC_PM_NORMAL     2'b01
`define AFMC_PM_LOWPOW     2'b10

// measurement modes
`define AFMC_MM_MANUAL     2'b00
`define AFMC_MM_SUPPLY     2'b01

// preset supply measurement settings: channel, gain, rate code
`define AFMC_SUP_CHAN      3'h5
`define AFMC_SUP_GAIN      2'h0
`define AFMC_SUP_RATE      3'h0

// reset values
`define AFMC_CTRL_RST      7'h01
`define AFMC_RATE_RST      3'h0
`define AFMC_MANUAL_RST    5'h00
`define AFMC_LP_DROP_RST   5'h05
`define AFMC_LP_ACC_RST    5'h10
`define AFMC_LP_CYC_RST    7'h40
`define AFMC_LP_RATE_RST   3'h6

// timing
`define AFMC_CLK_HZ        50000000
`define AFMC_PD_HOLD_US    172
`define AFMC_PD_HOLD_CYC   (`AFMC_PD_HOLD_US * 50)
`define AFMC_PF_MS_00      300
`define AFMC_PF_MS_01      590
`define AFMC_PF_MS_10      230
`define AFMC_PF_MS_11      460
`define AFMC_CYC_PER_MS    (`AFMC_CLK_HZ / 1000)

`endif

// ===== afmc_counter.v
/*
  loadable down counter with a done flag.
  assumes an active-low reset, asserted asynchronously and released synchronously by the top.
*/
`timescale 1ns/100ps
module afmc_counter
#(
  parameter W = 16
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] value,
  input  wire         dec,
  output wire         done
);
  reg [W-1:0] cnt_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= {W{1'b0}};
    else if (load)
      cnt_r <= value;
    else if (dec && cnt_r != {W{1'b0}})
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
  end
  assign done = (cnt_r == {W{1'b0}});
endmodule // afmc_counter

// ===== afmc_sclk_watch.v
/*
  watches the serial clock pin for a long high hold and reports sleep.
  assumes sclk is synchronous to the core clock.
*/
`timescale 1ns/100ps
module afmc_sclk_watch
#(
  parameter HOLD_CYC = 8600
)
(
  input  wire clk,
  input  wire rst_n,
  input  wire sclk,
  output reg  sleep_state
);
  reg  [15:0] hold_r;
  reg         sclk_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_r      <= 16'h0000;
      sclk_r      <= 1'b0;
      sleep_state <= 1'b0;
    end
    else
    begin
      sclk_r <= sclk;
      if (!sclk)
      begin
        hold_r      <= 16'h0000;
        sleep_state <= 1'b0;
      end
      else if (!sclk_r && !sleep_state)
        hold_r <= 16'h0001;
      else if (hold_r != 16'h0000 && !sleep_state)
      begin
        if (hold_r >= HOLD_CYC[15:0])
          sleep_state <= 1'b1;
        else
          hold_r <= hold_r + 16'h0001;
      end
    end
  end
endmodule // afmc_sclk_watch

// ===== afmc_top.v
/*
  adc filter and mode control: comb order, settling, measurement and
  operating modes, duty-cycled low power sequencing and sleep on sclk.
  assumes a wishbone classic master and a filter datapath that pulses
  filt_out_vld once per comb output.
*/
`timescale 1ns/100ps
`include "afmc_defs.vh"

// What this block does
// - normal mode, rates 10 to 80 hz: third-order comb
// - normal mode, rates 160 to 1280 hz: fifth-order comb
// - low power mode always uses fifth-order comb
// - first valid output after restart is output number comb order, counting from one
// - post-filter adds 300 ms for select 00, 590 ms for 01
// - post-filter adds 230 ms for select 10, 460 ms for 11
// - two-bit field picks supply or manual measurement
// - supply mode forces preset channel, gain and rate
// - manual settings kept while other mode active, restored after
// - high performance: buffer on, fast modulator clock
// - normal: buffer bypassed, slow modulator clock
// - low power: one result per 21 filter outputs at 640 hz plus 43 core clocks
// - low power: drop first 5 outputs, average next 16
// - low power: one result per 64-count cycle, 21 outputs then 43 core clocks with filter and reference off
// - low power filter rate and accumulate count are programmable
// - power-on reset clears the whole block without host action
// - sclk held high 172 us enters sleep
// - sclk low again leaves sleep
// - configuration survives sleep
module afmc_top
#(
  parameter PD_HOLD_CYC = `AFMC_PD_HOLD_CYC,
  parameter PF_CYC_00   = `AFMC_PF_MS_00 * `AFMC_CYC_PER_MS,
  parameter PF_CYC_01   = `AFMC_PF_MS_01 * `AFMC_CYC_PER_MS,
  parameter PF_CYC_10   = `AFMC_PF_MS_10 * `AFMC_CYC_PER_MS,
  parameter PF_CYC_11   = `AFMC_PF_MS_11 * `AFMC_CYC_PER_MS,
  parameter DATA_W      = 24
)
(
  input  wire              core_clk,
  input  wire              reset_n,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire              sclk,
  input  wire              filt_out_vld,
  input  wire [DATA_W-1:0] filt_out_data,
  output reg               filt_restart,
  output reg  [2:0]        comb_order,
  output reg  [2:0]        filt_rate,
  output reg  [2:0]        eff_chan,
  output reg  [1:0]        eff_gain,
  output reg               buf_enable,
  output reg               mod_clk_fast,
  output reg               filt_enable,
  output reg               vref_enable,
  output reg               result_valid,
  output reg  [DATA_W-1:0] result_data,
  output wire              sleep_state
);
  // reset release through two flops
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // configuration registers; reset only by power-on, never by sleep
  reg [1:0] op_mode_r;
  reg [1:0] measurement_mode_select_r;
  reg       post_filter_enable_r;
  reg       post_filter_select_hi_r;
  reg       post_filter_select_lo_r;
  reg [2:0] user_rate_r;
  reg [2:0] user_chan_r;
  reg [1:0] user_gain_r;
  reg [4:0] lp_drop_r;
  reg [4:0] lp_acc_r;
  reg [6:0] lp_cycle_r;
  reg [2:0] lp_rate_r;

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
  wire cfg_wr = wb_wr && (wb_adr_i == `AFMC_OFS_CTRL || wb_adr_i == `AFMC_OFS_RATE
                || wb_adr_i == `AFMC_OFS_MANUAL || wb_adr_i == `AFMC_OFS_LP);

  always @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      {post_filter_select_hi_r, post_filter_select_lo_r, post_filter_enable_r,
       measurement_mode_select_r, op_mode_r} <= `AFMC_CTRL_RST;
      user_rate_r <= `AFMC_RATE_RST;
      {user_gain_r, user_chan_r} <= `AFMC_MANUAL_RST;
      lp_drop_r   <= `AFMC_LP_DROP_RST;
      lp_acc_r    <= `AFMC_LP_ACC_RST;
      lp_cycle_r  <= `AFMC_LP_CYC_RST;
      lp_rate_r   <= `AFMC_LP_RATE_RST;
    end
    else if (wb_wr)
    begin
      case (wb_adr_i)
        `AFMC_OFS_CTRL:
        begin
          op_mode_r                 <= wb_dat_i[1:0];
          measurement_mode_select_r <= wb_dat_i[3:2];
          post_filter_enable_r      <= wb_dat_i[4];
          post_filter_select_lo_r   <= wb_dat_i[5];
          post_filter_select_hi_r   <= wb_dat_i[6];
        end
        `AFMC_OFS_RATE:
          user_rate_r <= wb_dat_i[2:0];
        `AFMC_OFS_MANUAL:
        begin
          user_chan_r <= wb_dat_i[2:0];
          user_gain_r <= wb_dat_i[4:3];
        end
        `AFMC_OFS_LP:
        begin
          lp_drop_r  <= wb_dat_i[4:0];
          lp_acc_r   <= wb_dat_i[12:8];
          lp_cycle_r <= wb_dat_i[22:16];
          lp_rate_r  <= wb_dat_i[26:24];
        end
        default:
          lp_drop_r <= lp_drop_r;
      endcase
    end
  end

  afmc_sclk_watch #(.HOLD_CYC(PD_HOLD_CYC)) u_watch
  (
    .clk         (core_clk),
    .rst_n       (rst_n_r),
    .sclk        (sclk),
    .sleep_state (sleep_state)
  );

  // effective settings
  wire lowpow = (op_mode_r == `AFMC_PM_LOWPOW);
  wire supply = (measurement_mode_select_r == `AFMC_MM_SUPPLY);
  wire [2:0] rate_nxt = supply ? `AFMC_SUP_RATE : (lowpow ? lp_rate_r : user_rate_r);
  wire [2:0] order_nxt = (lowpow || rate_nxt[2]) ? 3'd5 : 3'd3;
  reg  [31:0] pf_cyc;
  always @*
  begin
    case ({post_filter_select_hi_r, post_filter_select_lo_r})
      2'b00:   pf_cyc = PF_CYC_00;
      2'b01:   pf_cyc = PF_CYC_01;
      2'b10:   pf_cyc = PF_CYC_10;
      default: pf_cyc = PF_CYC_11;
    endcase
  end

  // settling, post-filter and low power sequencing
  localparam ST_RUN    = 2'd0;
  localparam ST_SETTLE = 2'd1;
  localparam ST_POST   = 2'd2;
  reg [1:0]        state_r;
  reg [6:0]        lp_idx_r;
  reg [2:0]        settle_r;
  reg [DATA_W+4:0] acc_r;
  wire             pf_done;
  wire             pf_load = filt_restart;

  afmc_counter #(.W(32)) u_pf
  (
    .clk   (core_clk),
    .rst_n (rst_n_r),
    .load  (pf_load),
    .value (post_filter_enable_r ? pf_cyc : 32'h0000_0000),
    .dec   (state_r == ST_POST),
    .done  (pf_done)
  );

  wire [6:0] drop_end = {2'b00, lp_drop_r};
  wire [6:0] acc_end  = drop_end + {2'b00, lp_acc_r};
  wire       lp_active = (lp_idx_r < acc_end);

  // average of the accumulated outputs; an accumulate count of zero is not supported
  wire [DATA_W+4:0] avg_sum = acc_r + {5'd0, filt_out_data};
  wire [DATA_W+4:0] avg_q   = avg_sum / {{DATA_W{1'b0}}, lp_acc_r};

  always @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r      <= ST_SETTLE;
      settle_r     <= 3'd0;
      lp_idx_r     <= 7'd0;
      acc_r        <= {(DATA_W+5){1'b0}};
      filt_restart <= 1'b1;
      comb_order   <= 3'd3;
      filt_rate    <= 3'd0;
      eff_chan     <= 3'd0;
      eff_gain     <= 2'd0;
      buf_enable   <= 1'b1;
      mod_clk_fast <= 1'b1;
      filt_enable  <= 1'b0;
      vref_enable  <= 1'b0;
      result_valid <= 1'b0;
      result_data  <= {DATA_W{1'b0}};
    end
    else
    begin
      filt_restart <= cfg_wr;
      result_valid <= 1'b0;
      comb_order   <= order_nxt;
      filt_rate    <= rate_nxt;
      eff_chan     <= supply ? `AFMC_SUP_CHAN : user_chan_r;
      eff_gain     <= supply ? `AFMC_SUP_GAIN : user_gain_r;
      buf_enable   <= (op_mode_r == `AFMC_PM_HIPERF);
      mod_clk_fast <= (op_mode_r == `AFMC_PM_HIPERF);
      filt_enable  <= !sleep_state && (!lowpow || lp_active);
      vref_enable  <= !sleep_state && (!lowpow || lp_active);
      if (filt_restart || sleep_state)
      begin
        state_r  <= ST_SETTLE;
        settle_r <= 3'd0;
        lp_idx_r <= 7'd0;
        acc_r    <= {(DATA_W+5){1'b0}};
      end
      else if (lowpow)
      begin
        // comb and reference restart every cycle, so settling is the drop count
        if (filt_out_vld || !lp_active)
        begin
          lp_idx_r <= (lp_idx_r + 7'd1 >= lp_cycle_r) ? 7'd0 : lp_idx_r + 7'd1;
          if (lp_idx_r >= drop_end && lp_active)
            acc_r <= acc_r + {5'd0, filt_out_data};
          if (lp_idx_r + 7'd1 == acc_end)
          begin
            result_valid <= 1'b1;
            result_data  <= avg_q[DATA_W-1:0];
            acc_r        <= {(DATA_W+5){1'b0}};
          end
        end
      end
      else
      begin
        case (state_r)
          ST_SETTLE:
            if (filt_out_vld)
            begin
              settle_r <= settle_r + 3'd1;
              if (settle_r + 3'd1 >= comb_order)
              begin
                if (post_filter_enable_r)
                  state_r <= ST_POST;
                else
                begin
                  // the order-th output is already settled, so it is delivered
                  state_r      <= ST_RUN;
                  result_valid <= 1'b1;
                  result_data  <= filt_out_data;
                end
              end
            end
          ST_POST:
            if (pf_done)
              state_r <= ST_RUN;
          ST_RUN:
            if (filt_out_vld)
            begin
              result_valid <= 1'b1;
              result_data  <= filt_out_data;
            end
          default:
            state_r <= ST_SETTLE;
        endcase
      end
    end
  end

  // wishbone slave: single registered ack, one cycle after the request
  always @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `AFMC_OFS_CTRL:
            wb_dat_o <= {25'd0, post_filter_select_hi_r, post_filter_select_lo_r,
                         post_filter_enable_r, measurement_mode_select_r, op_mode_r};
          `AFMC_OFS_RATE:   wb_dat_o <= {29'd0, user_rate_r};
          `AFMC_OFS_MANUAL: wb_dat_o <= {27'd0, user_gain_r, user_chan_r};
          `AFMC_OFS_LP:
            wb_dat_o <= {5'd0, lp_rate_r, 1'b0, lp_cycle_r, 3'd0, lp_acc_r, 3'd0, lp_drop_r};
          `AFMC_OFS_STATUS:
            wb_dat_o <= {24'd0, comb_order, state_r, sleep_state, filt_enable, result_valid};
          `AFMC_OFS_RESULT:
            wb_dat_o <= {{(32-DATA_W){1'b0}}, result_data};
          default:
            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // afmc_top

// ===== afmc_top_assertions.sv
/*
  port checker for afmc_top: bus answer, comb order, sleep, restart, results.
  assumes it is bound into afmc_top and sclk starts low after reset.
*/
`timescale 1ns/100ps
module afmc_chk
#(
  parameter PD_HOLD_CYC = 20
)
(
  input wire       core_clk,
  input wire       reset_n,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire       wb_ack_o,
  input wire       sclk,
  input wire       filt_out_vld,
  input wire       filt_restart,
  input wire [2:0] comb_order,
  input wire [2:0] filt_rate,
  input wire       buf_enable,
  input wire       mod_clk_fast,
  input wire       filt_enable,
  input wire       vref_enable,
  input wire       result_valid,
  input wire       sleep_state
);
  // counts consecutive high cycles of sclk; a counter keeps the long hold cheap
  reg [15:0] hi_cnt_r;
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      hi_cnt_r <= 16'h0000;
    else
      hi_cnt_r <= sclk ? hi_cnt_r + 16'h0001 : 16'h0000;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  high_order_a: assert property (filt_rate[2] |-> comb_order == 3'h5)
    else $error("high rate without fifth-order comb");
  buf_clock_a: assert property (buf_enable == mod_clk_fast)
    else $error("buffer and modulator clock disagree");
  sleep_quiet_a: assert property (sleep_state [*2] |-> !filt_enable && !vref_enable)
    else $error("filter or reference on in sleep");
  sleep_entry_a: assert property ($rose(sleep_state) |-> hi_cnt_r >= PD_HOLD_CYC - 1)
    else $error("sleep entered before hold time");
  sleep_due_a: assert property (hi_cnt_r == PD_HOLD_CYC + 2 |-> sleep_state)
    else $error("sleep not entered after hold time");
  sleep_wake_a: assert property (sleep_state && !sclk |=> !sleep_state)
    else $error("sleep kept with sclk low");
  cfg_restart_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i < 8'h10
    |-> filt_restart) else $error("config write without restart");
  result_cause_a: assert property (result_valid |-> $past(filt_out_vld))
    else $error("result without filter output");
endmodule // afmc_chk

bind afmc_top afmc_chk #(.PD_HOLD_CYC(PD_HOLD_CYC)) u_chk (.core_clk(core_clk),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .sclk(sclk),
  .filt_out_vld(filt_out_vld), .filt_restart(filt_restart), .comb_order(comb_order),
  .filt_rate(filt_rate), .buf_enable(buf_enable), .mod_clk_fast(mod_clk_fast),
  .filt_enable(filt_enable), .vref_enable(vref_enable), .result_valid(result_valid),
  .sleep_state(sleep_state));

// ===== afmc_filt_model.sv
/*
  comb datapath model: one output every 8 clocks while enabled, value 16*index.
  assumes the index restarts on filt_restart or when the filter is switched off.
*/
`timescale 1ns/100ps
module afmc_filt_model
(
  input  wire        core_clk,
  input  wire        filt_enable,
  input  wire        filt_restart,
  output reg         filt_out_vld,
  output reg  [23:0] filt_out_data
);
  reg [2:0]  tick_r;
  reg [23:0] idx_r;
  initial
  begin
    filt_out_vld = 1'b0;
    filt_out_data = 24'h00_0000;
  end
  always @(posedge core_clk)
  begin
    filt_out_vld <= 1'b0;
    // data is only meaningful with the strobe, so it toggles otherwise
    filt_out_data <= ~filt_out_data;
    if (filt_restart || !filt_enable)
    begin
      tick_r <= 3'h0;
      idx_r <= 24'h00_0000;
    end
    else
    begin
      tick_r <= tick_r + 3'h1;
      if (tick_r == 3'h7)
      begin
        filt_out_vld <= 1'b1;
        filt_out_data <= idx_r << 4;
        idx_r <= idx_r + 24'h00_0001;
      end
    end
  end
endmodule // afmc_filt_model

// ===== adc_filter_mode_control_bench.sv
/*
  self-checking bench for afmc_top with the comb datapath model.
  assumes short hold and post-filter counts set at the instance.
*/
`timescale 1ns/100ps
module adc_filter_mode_control_bench;
  reg         core_clk, reset_n, cyc, we, sclk;
  reg  [7:0]  adr;
  reg  [31:0] wdat, r;
  reg  [3:0]  sel;
  wire [31:0] rdat;
  wire        ack, vld, rst_p, rv, fen, ven, buf_en, fast, slp;
  wire [23:0] fdat, res;
  wire [2:0]  ord, rate, chan;
  wire [1:0]  gain;
  integer     fails, n_compared, i, n, k, lo, pf;
  afmc_top #(.PD_HOLD_CYC(20), .PF_CYC_00(10), .PF_CYC_01(40), .PF_CYC_10(20),
    .PF_CYC_11(30)) dut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sclk(sclk), .filt_out_vld(vld),
    .filt_out_data(fdat), .filt_restart(rst_p), .comb_order(ord), .filt_rate(rate),
    .eff_chan(chan), .eff_gain(gain), .buf_enable(buf_en), .mod_clk_fast(fast),
    .filt_enable(fen), .vref_enable(ven), .result_valid(rv), .result_data(res),
    .sleep_state(slp));
  afmc_filt_model u_model (.core_clk(core_clk), .filt_enable(fen),
    .filt_restart(rst_p), .filt_out_vld(vld), .filt_out_data(fdat));
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task tk(input integer c);
    repeat (c) @(posedge core_clk);
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
  begin
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge core_clk);
    end
    if (n >= 20) fails = fails + 1;
    r = rdat;
    cyc <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  // waits for the next result, counting filter outputs and filter-off clocks
  task wait_res;
  begin
    n = 0;
    k = 0;
    lo = 0;
    @(posedge core_clk);
    while (rv !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      n = n + 1;
      if (vld === 1'b1) k = k + 1;
      if (fen === 1'b0) lo = lo + 1;
    end
    if (n >= 3000) fails = fails + 1;
  end
  endtask
  task t_order;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      wb(1, 8'h00, i / 8);
      wb(1, 8'h04, i % 8);
      tk(2);
      chk(ord, (i % 8) < 4 ? 3'h3 : 3'h5);
      chk({buf_en, fast}, i < 8 ? 2'h3 : 2'h0);
    end
    wb(1, 8'h04, 32'h0000_0000);
    wb(1, 8'h00, 32'h0000_0002);
    tk(2);
    chk(ord, 3'h5);
  end
  endtask
  task t_meas;
  begin
    wb(1, 8'h00, 32'h0000_0001);
    wb(1, 8'h04, 32'h0000_0003);
    wb(1, 8'h08, 32'h0000_001A);
    tk(2);
    chk({rate, gain, chan}, {3'h3, 2'h3, 3'h2});
    wb(1, 8'h00, 32'h0000_0005);
    tk(2);
    chk({rate, gain, chan}, {3'h0, 2'h0, 3'h5});
    wb(1, 8'h00, 32'h0000_0001);
    tk(2);
    chk({rate, gain, chan}, {3'h3, 2'h3, 3'h2});
    wb(1, 8'h04, 32'h0000_0000);
  end
  endtask
  task t_settle;
  begin
    for (i = 0; i < 5; i = i + 1)
    begin
      pf = (i == 0) ? 10 : (i == 1) ? 40 : (i == 2) ? 20 : 30;
      wb(1, 8'h00, i < 4 ? 32'h0000_0011 | (i << 5) : 32'h0000_0001);
      wait_res;
      if (i == 4)
        chk(k, 3);
      else
        chk(k >= 4 + (pf - 1) / 8 && k <= 5 + pf / 8, 1);
    end
  end
  endtask
  task t_lp;
  begin
    wb(1, 8'h00, 32'h0000_0002);
    for (i = 0; i < 2; i = i + 1)
    begin
      wb(1, 8'h0C, i == 0 ? 32'h0640_1005 : 32'h0640_0805);
      wait_res;
      wait_res;
      chk(k, i == 0 ? 21 : 13);
      chk(res, i == 0 ? 24'h00_00C8 : 24'h00_0088);
      chk(lo >= 63 - k && lo <= 66 - k, 1);
    end
  end
  endtask
  task t_sleep;
  begin
    sclk <= 1'b1;
    tk(17);
    sclk <= 1'b0;
    tk(2);
    chk(slp, 1'b0);
    sclk <= 1'b1;
    tk(24);
    chk({slp, fen, ven}, 3'h4);
    sclk <= 1'b0;
    tk(3);
    chk(slp, 1'b0);
    wb(0, 8'h0C, 32'h0000_0000);
    chk(r, 32'h0640_0805);
  end
  endtask
  task t_por;
  begin
    reset_n <= 1'b0;
    tk(5);
    reset_n <= 1'b1;
    tk(3);
    wb(0, 8'h00, 32'h0000_0000);
    chk(r, 32'h0000_0001);
    wb(0, 8'h0C, 32'h0000_0000);
    chk(r, 32'h0640_1005);
    wb(0, 8'h20, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    chk({ord, buf_en}, 4'h6);
    // a write without byte lane 0 must leave the register alone
    sel <= 4'h0;
    wb(1, 8'h04, 32'h0000_0007);
    sel <= 4'hF;
    wb(0, 8'h04, 32'h0000_0000);
    chk(r, 32'h0000_0000);
  end
  endtask
  task test_done;
  begin
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    fails = 0;
    n_compared = 0;
    reset_n = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'hF;
    sclk = 1'b0;
    tk(5);
    reset_n <= 1'b1;
    tk(3);
    t_order;
    t_meas;
    t_settle;
    t_lp;
    t_sleep;
    t_por;
    test_done;
  end
  initial
  begin
    #400000;
    fails = fails + 1;
    test_done;
  end
endmodule // adc_filter_mode_control_bench
